/* File: core/wdrlp_pkg.sv */
package wdrlp_pkg;
    // Address map and fields.
    localparam logic [15:0] CLEAR_ADDR = 16'h1ff0;
    localparam int CLEAR_BIT = 0;
    localparam logic [15:0] RAM_LO = 16'h0080;
    localparam logic [15:0] RAM_HI = 16'h01ff;
    localparam logic [15:0] ROM_LO = 16'h0f00;
    localparam logic [15:0] ROM_HI = 16'h1fff;
    // Timing counts in internal clock cycles.
    localparam int STARTUP_CYCLES = 4064;
    localparam int PULL_CYCLES = 4;
    localparam int WDOG_TIMEOUT_DEFAULT = 65536;
    localparam int CNT_W = 20;

    // Operating mode picked at reset release.
    typedef enum logic {WDRLP_SINGLE_CHIP, WDRLP_SELF_CHECK} wdrlp_mode_t;

    // Power state of the core.
    typedef enum logic [1:0] {WDRLP_RUN, WDRLP_WAIT, WDRLP_STOP, WDRLP_START} wdrlp_pwr_t;

    // One CPU bus cycle.
    typedef struct packed {
        logic valid;
        logic write;
        logic opfetch;
        logic [15:0] addr;
        logic [7:0] wdata;
    } wdrlp_bus_t;

    // Instruction events decoded by the CPU.
    typedef struct packed {
        logic halt_exec;
        logic wait_exec;
    } wdrlp_instr_t;
endpackage

/* File: core/wdrlp_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module wdrlp_counter #(
    parameter int TIMEOUT = wdrlp_pkg::WDOG_TIMEOUT_DEFAULT
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Control.
    input wire logic clear,
    input wire logic count_en,
    // Status.
    output logic expired
);
    // Counter state.
    typedef struct packed {
        logic [wdrlp_pkg::CNT_W-1:0] cnt;
        logic exp;
    } wdrlp_cnt_state_t;

    localparam logic [wdrlp_pkg::CNT_W-1:0] LAST = wdrlp_pkg::CNT_W'(TIMEOUT - 1);

    wdrlp_cnt_state_t s_q;
    wdrlp_cnt_state_t s_d;

    // Clear wins over counting; expiry is a one-cycle pulse at the last count.
    always_comb begin
        s_d = s_q;
        s_d.exp = 1'b0;
        if (clear) begin
            s_d.cnt = '0;
        end else if (count_en) begin
            if (s_q.cnt == LAST) begin
                s_d.cnt = '0;
                s_d.exp = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign expired = s_q.exp;
endmodule // wdrlp_counter
`default_nettype wire

/* File: core/wdrlp_pull.sv */
`timescale 1ns/1ps
`default_nettype none
module wdrlp_pull (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Request and pin pulldown.
    input wire logic src_active,
    input wire logic start,
    output logic pull
);
    // Stretcher state.
    typedef struct packed {
        logic [2:0] cnt;
        logic pull;
    } wdrlp_pull_state_t;

    wdrlp_pull_state_t s_q;
    wdrlp_pull_state_t s_d;

    // Pull the pin while a source lasts or for at least the minimum stretch.
    always_comb begin
        s_d = s_q;
        if (start) begin
            s_d.cnt = 3'(wdrlp_pkg::PULL_CYCLES);
        end else if (s_q.cnt != 3'h0) begin
            s_d.cnt = s_q.cnt - 3'h1;
        end
        s_d.pull = src_active || start || (s_d.cnt != 3'h0);
    end

    // State register.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pull = s_q.pull;
endmodule // wdrlp_pull
`default_nettype wire

/* File: core/wdrlp_top.sv */
// Notes on behaviour
// - Watchdog counts and resets the chip when firmware fails to clear it.
// - Watchdog presence is a fixed build option.
// - Watchdog expiry turns on the reset pin pulldown.
// - Writing zero to bit 0 of 1FF0 clears the counter.
// - Reads of 1FF0 return program memory, not watchdog state.
// - Watchdog keeps counting in wait mode.
// - Entering stop clears the watchdog counter.
// - Reset exit from stop holds the counter clear through 4064 cycles.
// - Interrupt exit from stop counts through the 4064-cycle startup.
// - Watchdog inhibited in test and self-check modes.
// - After watchdog reset the mode is chosen by normal rules.
// - Opcode fetch outside RAM or program memory resets the chip.
// - Single-chip by default; self-check needs test level and port B line 1.
// - Halt stops the oscillator, freezing timer and watchdog.
// - Entering stop clears the interrupt mask bit only.
// - Only external interrupt or external reset ends stop.
// - Disabled halt instruction causes a chip reset.
// - Wait suspends the CPU; timer or serial interrupts end it.
// - Entering wait clears the interrupt mask bit only.
// - Internal resets pull the pin low for their length or four cycles; the code pulls it for their length plus three cycles.
// - Oscillator restart waits 4064 cycles before releasing the CPU.
`timescale 1ns/1ps
`default_nettype none
module wdrlp_top #(
    parameter bit WDOG_PRESENT = 1'b1,
    parameter bit HALT_DISABLED = 1'b1,
    parameter int WDOG_TIMEOUT = wdrlp_pkg::WDOG_TIMEOUT_DEFAULT,
    parameter int STARTUP = wdrlp_pkg::STARTUP_CYCLES
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // CPU bus and instruction events.
    input wire wdrlp_pkg::wdrlp_bus_t bus,
    input wire wdrlp_pkg::wdrlp_instr_t instr,
    // External pins, taken as synchronous levels.
    input wire logic ext_reset_n,
    input wire logic ext_irq,
    input wire logic elevated_test_level,
    input wire logic port_b_line_one,
    input wire logic test_mode,
    // Wake sources for wait mode.
    input wire logic timer_irq,
    input wire logic serial_irq,
    // Chip control outputs.
    output logic chip_reset,
    output logic reset_pin_o,
    output logic reset_pin_oe,
    output logic cpu_hold,
    output logic osc_run,
    output logic mask_bit_clear,
    output logic watchdog_chip_reset,
    output wdrlp_pkg::wdrlp_mode_t mode
);
    // Whole state of the control logic.
    typedef struct packed {
        wdrlp_pkg::wdrlp_pwr_t pwr;
        logic [12:0] start_cnt;
        logic start_by_reset;
        logic ext_rst_d;
        logic chip_reset;
        logic cpu_hold;
        logic osc_run;
        logic mask_clr;
        logic wd_rst;
        logic mode_src;
        wdrlp_pkg::wdrlp_mode_t mode;
    } wdrlp_state_t;

    localparam logic [12:0] START_LAST = 13'(STARTUP - 1);

    wdrlp_state_t s_q;
    wdrlp_state_t s_d;
    logic wd_clear;
    logic wd_count;
    logic wd_expired;
    logic illegal_fetch;
    logic halt_reset;
    logic ext_rst;
    logic ext_fall;
    logic int_src;
    logic pull;

    assign ext_rst = !ext_reset_n;
    assign ext_fall = ext_rst && !s_q.ext_rst_d;

    // A fetch outside both implemented regions is illegal.
    assign illegal_fetch = bus.valid && bus.opfetch &&
        !((bus.addr >= wdrlp_pkg::RAM_LO && bus.addr <= wdrlp_pkg::RAM_HI) ||
          (bus.addr >= wdrlp_pkg::ROM_LO && bus.addr <= wdrlp_pkg::ROM_HI));

    // A halt with the instruction disabled becomes a reset.
    assign halt_reset = instr.halt_exec && HALT_DISABLED && s_q.pwr == wdrlp_pkg::WDRLP_RUN;

    // Watchdog clear: write of zero in bit 0; reads are left to program memory.
    always_comb begin
        wd_clear = 1'b0;
        if (bus.valid && bus.write && bus.addr == wdrlp_pkg::CLEAR_ADDR) begin
            wd_clear = !bus.wdata[wdrlp_pkg::CLEAR_BIT];
        end
        if (s_d.pwr == wdrlp_pkg::WDRLP_STOP) begin
            wd_clear = 1'b1;
        end
        if (s_q.pwr == wdrlp_pkg::WDRLP_START && s_q.start_by_reset) begin
            wd_clear = 1'b1;
        end
        if (s_q.chip_reset && s_q.pwr != wdrlp_pkg::WDRLP_START) begin
            wd_clear = 1'b1;
        end
    end

    // Counting runs in run, wait and interrupt startup; frozen in stop and test modes.
    assign wd_count = WDOG_PRESENT && !test_mode &&
        s_q.mode != wdrlp_pkg::WDRLP_SELF_CHECK &&
        s_q.pwr != wdrlp_pkg::WDRLP_STOP;

    // Internal reset sources seen by the pin stretcher. The chip reset itself is left out:
    // it follows the pulldown, so feeding it back would keep the pin pulled for ever.
    assign int_src = wd_expired || illegal_fetch || halt_reset;

    // Watchdog counter.
    wdrlp_counter #(
        .TIMEOUT(WDOG_TIMEOUT)
    ) u_counter (
        .sys_clk(sys_clk),
        .reset(reset),
        .clear(wd_clear),
        .count_en(wd_count),
        .expired(wd_expired)
    );

    // Reset pin pulldown stretcher.
    wdrlp_pull u_pull (
        .sys_clk(sys_clk),
        .reset(reset),
        .src_active(int_src),
        .start(wd_expired || illegal_fetch || halt_reset || ext_fall),
        .pull(pull)
    );

    // Power state, startup delay, chip reset and mode selection.
    always_comb begin
        s_d = s_q;
        s_d.ext_rst_d = ext_rst;
        s_d.mask_clr = 1'b0;
        s_d.wd_rst = wd_expired && WDOG_PRESENT;
        s_d.chip_reset = ext_rst || wd_expired || illegal_fetch || halt_reset || pull;
        case (s_q.pwr)
            wdrlp_pkg::WDRLP_RUN: begin
                if (instr.halt_exec && !HALT_DISABLED && !s_d.chip_reset) begin
                    s_d.pwr = wdrlp_pkg::WDRLP_STOP;
                    s_d.osc_run = 1'b0;
                    s_d.mask_clr = 1'b1;
                end else if (instr.wait_exec && !s_d.chip_reset) begin
                    s_d.pwr = wdrlp_pkg::WDRLP_WAIT;
                    s_d.cpu_hold = 1'b1;
                    s_d.mask_clr = 1'b1;
                end
            end
            wdrlp_pkg::WDRLP_WAIT: begin
                if (timer_irq || serial_irq || ext_irq || s_d.chip_reset) begin
                    s_d.pwr = wdrlp_pkg::WDRLP_RUN;
                    s_d.cpu_hold = 1'b0;
                end
            end
            wdrlp_pkg::WDRLP_STOP: begin
                s_d.chip_reset = ext_rst;
                if (ext_irq || ext_rst) begin
                    s_d.pwr = wdrlp_pkg::WDRLP_START;
                    s_d.osc_run = 1'b1;
                    s_d.start_by_reset = ext_rst;
                    s_d.start_cnt = '0;
                end
            end
            default: begin
                if (ext_rst) begin
                    s_d.start_by_reset = 1'b1;
                end
                if (s_q.start_cnt == START_LAST) begin
                    s_d.pwr = wdrlp_pkg::WDRLP_RUN;
                    s_d.cpu_hold = 1'b0;
                end else begin
                    s_d.start_cnt = s_q.start_cnt + 13'h1;
                end
            end
        endcase
        // Power-on, external and watchdog resets may change the mode. The source is kept
        // until the chip reset ends, because the watchdog pulse is long gone by then.
        if (ext_rst || wd_expired) begin
            s_d.mode_src = 1'b1;
        end
        if (s_q.chip_reset && !s_d.chip_reset) begin
            s_d.mode_src = 1'b0;
            if (s_q.mode_src) begin
                s_d.mode = (elevated_test_level && port_b_line_one) ?
                    wdrlp_pkg::WDRLP_SELF_CHECK : wdrlp_pkg::WDRLP_SINGLE_CHIP;
            end
        end
        if (s_d.pwr == wdrlp_pkg::WDRLP_START) begin
            s_d.cpu_hold = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_q.pwr <= wdrlp_pkg::WDRLP_START;
            s_q.start_cnt <= '0;
            s_q.start_by_reset <= 1'b1;
            s_q.ext_rst_d <= 1'b0;
            s_q.chip_reset <= 1'b1;
            s_q.cpu_hold <= 1'b1;
            s_q.osc_run <= 1'b1;
            s_q.mask_clr <= 1'b0;
            s_q.wd_rst <= 1'b0;
            s_q.mode_src <= 1'b1;
            s_q.mode <= wdrlp_pkg::WDRLP_SINGLE_CHIP;
        end else begin
            s_q <= s_d;
        end
    end

    // Pin output is a registered pulldown; the pin level driven is always low.
    assign reset_pin_o = 1'b0;
    assign reset_pin_oe = pull;
    assign chip_reset = s_q.chip_reset;
    assign cpu_hold = s_q.cpu_hold;
    assign osc_run = s_q.osc_run;
    assign mask_bit_clear = s_q.mask_clr;
    assign watchdog_chip_reset = s_q.wd_rst;
    assign mode = s_q.mode;
endmodule // wdrlp_top
`default_nettype wire

/* File: dv/wdrlp_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module wdrlp_chk #(
    parameter bit HALT_DISABLED = 1'b1
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Requests from the CPU.
    input wire wdrlp_pkg::wdrlp_bus_t bus,
    input wire wdrlp_pkg::wdrlp_instr_t instr,
    // Chip control outputs.
    input wire logic chip_reset,
    input wire logic reset_pin_o,
    input wire logic reset_pin_oe,
    input wire logic cpu_hold,
    input wire logic mask_bit_clear,
    input wire logic watchdog_chip_reset,
    input wire wdrlp_pkg::wdrlp_mode_t mode
);
    logic live;
    logic bad_fetch;
    // Code runs only out of reset and hold; a fetch outside both memories is flagged.
    assign live = !chip_reset && !cpu_hold;
    assign bad_fetch = live && bus.valid && bus.opfetch && !(bus.addr inside
        {[wdrlp_pkg::RAM_LO:wdrlp_pkg::RAM_HI], [wdrlp_pkg::ROM_LO:wdrlp_pkg::ROM_HI]});
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_expiry_resets_chip: assert property (watchdog_chip_reset |-> chip_reset)
        else $error("Expiry without chip reset.");
    a_expiry_pulls_pin: assert property ($rose(watchdog_chip_reset) |=> reset_pin_oe)
        else $error("Expiry did not pull the reset pin.");
    a_pull_min_len: assert property ($rose(reset_pin_oe) |-> reset_pin_oe [*4])
        else $error("Reset pin pulldown too short.");
    a_pin_drives_low: assert property (reset_pin_oe |-> !reset_pin_o)
        else $error("Reset pin driven high.");
    a_bad_fetch_reset: assert property (bad_fetch |=> chip_reset)
        else $error("Illegal fetch did not reset.");
    a_halt_to_reset: assert property (HALT_DISABLED && instr.halt_exec && live |=> chip_reset)
        else $error("Disabled halt did not reset.");
    a_wait_entry: assert property (instr.wait_exec && live |=> cpu_hold && mask_bit_clear)
        else $error("Wait entry wrong.");
    a_expiry_one_pulse: assert property (watchdog_chip_reset |=> !watchdog_chip_reset)
        else $error("Expiry pulse too long.");
    a_mode_held: assert property (!chip_reset && !$past(chip_reset) && !$past(chip_reset, 2)
        |-> $stable(mode))
        else $error("Mode changed outside reset.");
    // Main scenarios reached.
    c_expiry: cover property (watchdog_chip_reset);
    c_bad_fetch: cover property (bad_fetch);
    c_wait: cover property (mask_bit_clear);
endmodule // wdrlp_chk
`default_nettype wire

/* File: dv/wdrlp_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module wdrlp_cpu_model (
    // Clock.
    input wire logic sys_clk,
    // Bus cycle and instruction events toward the core.
    output var wdrlp_pkg::wdrlp_bus_t bus,
    output var wdrlp_pkg::wdrlp_instr_t instr
);
    // Idle bus at time zero.
    initial begin
        bus = '0;
        instr = '0;
    end
    // One bus cycle, held across one full edge, then dropped.
    task automatic access(input logic wr, input logic op, input logic [15:0] a,
        input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        bus = '{1'b1, wr, op, a, d};
        @(posedge sys_clk);
        #1;
        bus = '0;
    endtask
    // Firmware keep-alive writes zero into the clear bit.
    task automatic keep_alive(input logic [7:0] d);
        access(1'b1, 1'b0, wdrlp_pkg::CLEAR_ADDR, d & 8'hfe);
    endtask
    // One-cycle halt or wait event; halt reaches both the halt-disabled and the halt-enabled build.
    task automatic exec(input logic halt, input logic wt);
        @(posedge sys_clk);
        #1;
        instr = '{halt, wt};
        @(posedge sys_clk);
        #1;
        instr = '0;
    endtask
endmodule // wdrlp_cpu_model
`default_nettype wire

/* File: dv/watchdog_reset_lowpower_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module watchdog_reset_lowpower_control_tb;
    localparam int WD = 64;
    localparam int ST = 16;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic ext_reset_n = 1'b1;
    logic ext_irq = 1'b0;
    logic elevated_test_level = 1'b0;
    logic port_b_line_one = 1'b0;
    logic test_mode = 1'b0;
    logic timer_irq = 1'b0;
    logic serial_irq = 1'b0;
    logic chip_reset, reset_pin_o, reset_pin_oe, cpu_hold, osc_run, mask_bit_clear;
    logic watchdog_chip_reset;
    logic bad;
    logic s_osc_run, s_cpu_hold, s_mask, s_wd;
    wdrlp_pkg::wdrlp_bus_t bus;
    wdrlp_pkg::wdrlp_instr_t instr;
    wdrlp_pkg::wdrlp_mode_t mode;
    int mismatches = 0;
    int samples_checked = 0;
    int wd_seen = 0;
    int n;
    logic [31:0] lfsr_q = 32'h9c0801eb;
    logic [15:0] addrs [14] = '{16'h007f, 16'h0080, 16'h01ff, 16'h0200, 16'h0eff, 16'h0f00,
        16'h1fff, 16'h2000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    wdrlp_cpu_model cpu_u (.sys_clk(sys_clk), .bus(bus), .instr(instr));
    wdrlp_top #(.WDOG_TIMEOUT(WD), .STARTUP(ST)) dut_u (.sys_clk(sys_clk), .reset(reset),
        .bus(bus), .instr(instr), .ext_reset_n(ext_reset_n), .ext_irq(ext_irq),
        .elevated_test_level(elevated_test_level), .port_b_line_one(port_b_line_one),
        .test_mode(test_mode), .timer_irq(timer_irq), .serial_irq(serial_irq),
        .chip_reset(chip_reset), .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe),
        .cpu_hold(cpu_hold), .osc_run(osc_run), .mask_bit_clear(mask_bit_clear),
        .watchdog_chip_reset(watchdog_chip_reset), .mode(mode));
    // Second core built with a working halt instruction, fed the same stimulus.
    wdrlp_top #(.HALT_DISABLED(1'b0), .WDOG_TIMEOUT(WD), .STARTUP(ST)) dut_stop_u (
        .sys_clk(sys_clk), .reset(reset), .bus(bus), .instr(instr),
        .ext_reset_n(ext_reset_n), .ext_irq(ext_irq),
        .elevated_test_level(elevated_test_level), .port_b_line_one(port_b_line_one),
        .test_mode(test_mode), .timer_irq(timer_irq), .serial_irq(serial_irq),
        .chip_reset(), .reset_pin_o(), .reset_pin_oe(), .cpu_hold(s_cpu_hold),
        .osc_run(s_osc_run), .mask_bit_clear(s_mask), .watchdog_chip_reset(s_wd), .mode());
    // Clock and expiry counter, sampled away from the launching edge.
    always #10 sys_clk = ~sys_clk;
    always @(negedge sys_clk) if (watchdog_chip_reset === 1'b1) wd_seen++;
    task automatic check(input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL t=%0t seen %b expected %b", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    endtask
    function automatic logic fetch_bad(input logic [15:0] a);
        return !((a >= wdrlp_pkg::RAM_LO && a <= wdrlp_pkg::RAM_HI) ||
            (a >= wdrlp_pkg::ROM_LO && a <= wdrlp_pkg::ROM_HI));
    endfunction
    task automatic recover();
        n = 0;
        while (!(chip_reset === 1'b0 && cpu_hold === 1'b0) && n < 300) begin
            step(1);
            n++;
        end
        check(n < 300, 1'b1);
    endtask
    task automatic wait_wd();
        n = 0;
        while (watchdog_chip_reset !== 1'b1 && n < 200) begin
            step(1);
            n++;
        end
    endtask
    // Main sequence.
    initial begin
        step(5);
        reset = 1'b0;
        recover();
        check(mode, wdrlp_pkg::WDRLP_SINGLE_CHIP);
        repeat (5) begin
            rnd();
            cpu_u.keep_alive(lfsr_q[7:0]);
            step(40);
        end
        check(wd_seen == 0, 1'b1);
        rnd();
        cpu_u.keep_alive(lfsr_q[7:0]);
        cpu_u.access(1'b1, 1'b0, wdrlp_pkg::CLEAR_ADDR, lfsr_q[15:8] | 8'h01);
        cpu_u.access(1'b0, 1'b0, wdrlp_pkg::CLEAR_ADDR, 8'h00);
        wait_wd();
        // The expiry pulse shows one edge after the last of WD counts from the clearing edge.
        check(n + 3 == WD, 1'b1);
        check(reset_pin_oe, 1'b1);
        check(reset_pin_o, 1'b0);
        recover();
        check(mode, wdrlp_pkg::WDRLP_SINGLE_CHIP);
        for (int i = 0; i < 14; i++) begin
            rnd();
            if (i >= 8) addrs[i] = lfsr_q[15:0] & 16'h3fff;
            cpu_u.keep_alive(8'h00);
            cpu_u.access(1'b0, 1'b1, addrs[i], 8'h00);
            bad = chip_reset;
            step(1);
            check(bad | chip_reset, fetch_bad(addrs[i]));
            recover();
        end
        // Halt resets the first core and stops the second one.
        cpu_u.exec(1'b1, 1'b0);
        check(s_mask, 1'b1);
        step(1);
        check(chip_reset, 1'b1);
        check(osc_run, 1'b1);
        check(s_osc_run, 1'b0);
        // Interrupt wake: startup delay counted by the watchdog from a cleared counter.
        ext_irq = 1'b1;
        step(1);
        ext_irq = 1'b0;
        step(ST - 1);
        check(s_cpu_hold, 1'b1);
        step(1);
        check(s_cpu_hold, 1'b0);
        check(s_osc_run, 1'b1);
        n = 0;
        while (s_wd !== 1'b1 && n < 200) begin
            step(1);
            n++;
        end
        check(n + ST == WD + 1, 1'b1);
        wait_wd();
        recover();
        for (int w = 0; w < 2; w++) begin
            cpu_u.keep_alive(8'h00);
            cpu_u.exec(1'b0, 1'b1);
            check(mask_bit_clear, 1'b1);
            step(5);
            check(cpu_hold, 1'b1);
            if (w == 0) timer_irq = 1'b1;
            else serial_irq = 1'b1;
            step(1);
            check(cpu_hold, 1'b0);
            timer_irq = 1'b0;
            serial_irq = 1'b0;
        end
        cpu_u.keep_alive(8'h00);
        cpu_u.exec(1'b0, 1'b1);
        wait_wd();
        check(n + 1 == WD, 1'b1);
        recover();
        test_mode = 1'b1;
        n = wd_seen;
        step(3 * WD);
        check(wd_seen == n, 1'b1);
        test_mode = 1'b0;
        elevated_test_level = 1'b1;
        port_b_line_one = 1'b1;
        ext_reset_n = 1'b0;
        step(2);
        check(reset_pin_oe, 1'b1);
        step(3);
        check(chip_reset, 1'b1);
        check(reset_pin_oe, 1'b0);
        ext_reset_n = 1'b1;
        recover();
        check(mode, wdrlp_pkg::WDRLP_SELF_CHECK);
        finish_test();
    end
    // Hang guard.
    initial begin
        #(20 * 20000);
        mismatches++;
        finish_test();
    end
endmodule // watchdog_reset_lowpower_control_tb
bind wdrlp_top wdrlp_chk #(.HALT_DISABLED(HALT_DISABLED)) chk_u (.sys_clk(sys_clk),
    .reset(reset), .bus(bus), .instr(instr), .chip_reset(chip_reset),
    .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe), .cpu_hold(cpu_hold),
    .mask_bit_clear(mask_bit_clear), .watchdog_chip_reset(watchdog_chip_reset), .mode(mode));
`default_nettype wire
